/* File: logic/clk_switch_cfg.svh */
// Offsets, field positions, reset values and timing counts of the clock switch block
`ifndef CLK_SWITCH_CFG_SVH
`define CLK_SWITCH_CFG_SVH
`define CS_ADDR_DIV 8'h95
`define CS_ADDR_SWITCH 8'h96
`define CS_ADDR_ENABLE 8'h97
`define CS_ADDR_TIMED 8'hC7
`define CS_TIMED_KEY1 8'hAA
`define CS_TIMED_KEY2 8'h55
`define CS_TIMED_OPEN_CYC 3'h4
`define CS_SWITCH_RESET 8'h30
`define CS_ENABLE_RESET 8'h30
`define CS_DIV_RESET 8'h00
`define CS_BIT_FAST_ST 5
`define CS_BIT_EXT_ST 3
`define CS_SEL_HI 2
`define CS_SEL_LO 1
`define CS_EXT_HI 7
`define CS_EXT_LO 6
`define CS_BIT_FAST_EN 5
`define CS_BIT_FAULT 0
`define CS_EXT_ON 2'h3
`endif

/* File: logic/clk_switch_pkg.sv */
// Types shared by the clock switch block
package clk_switch_pkg;
    typedef enum logic [1:0] {
        SRC_FAST = 2'h0,
        SRC_EXT = 2'h1,
        SRC_SLOW = 2'h2,
        SRC_RSVD = 2'h3
    } clk_src_t;
    typedef enum {
        SW_IDLE,
        SW_WAIT
    } sw_state_t;
endpackage

/* File: logic/sync2.sv */
// Two flip-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    // First stage feeds only the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule
`default_nettype wire

/* File: logic/sys_clk_divider.sv */
// Integer divider from the oscillator clock level to the system clock
`timescale 1ns/100ps
`default_nettype none
module sys_clk_divider (
    input wire logic clk,
    input wire logic rst,
    input wire logic osc_lvl,
    input wire logic osc_rise,
    input wire logic osc_fall,
    input wire logic [7:0] div,
    output logic sys_clk
);
    logic [7:0] cnt_r;
    logic half_r;

    // Count oscillator rising edges; each div rising edges toggle the divided clock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 8'h00;
            half_r <= 1'b0;
        end else if (div == 8'h00) begin
            cnt_r <= 8'h00;
            half_r <= osc_lvl;
        end else if (osc_rise) begin
            // A new ratio is used from the next rising edge, against the running count, no stop
            if (cnt_r + 8'h01 >= div) begin
                cnt_r <= 8'h00;
                half_r <= ~half_r;
            end else begin
                cnt_r <= cnt_r + 8'h01;
            end
        end
    end

    // Pass-through follows the oscillator, else the toggling half clock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sys_clk <= 1'b0;
        end else if (div == 8'h00) begin
            sys_clk <= osc_lvl;
        end else begin
            sys_clk <= half_r;
        end
    end

    logic unused_fall;
    assign unused_fall = osc_fall;
endmodule
`default_nettype wire

/* File: logic/clk_source_switch.sv */
// Clock source selection, enables, switch fault and divider control
`timescale 1ns/100ps
`default_nettype none
`include "clk_switch_cfg.svh"
module clk_source_switch (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic fast_osc_clk,
    input wire logic fast_osc_ready,
    input wire logic slow_osc_clk,
    input wire logic ext_input_clk,
    input wire logic ext_input_ready,
    input wire logic inapp_program_enable,
    output logic fast_osc_on,
    output logic ext_input_on,
    output logic shared_io_gpio,
    output clk_switch_pkg::clk_src_t active_src,
    output logic sys_clk
);
    import clk_switch_pkg::*;

    logic [4:0] pins_s;
    logic timed_armed_r;
    logic [2:0] timed_open_r;
    logic [1:0] sel_r;
    logic [1:0] ext_field_r;
    logic fast_en_r;
    logic fault_r;
    logic [7:0] div_r;
    clk_src_t active_r;
    logic osc_lvl_r;
    logic osc_prev_r;
    logic fast_en_eff;
    logic fast_st;
    logic ext_st;
    logic ext_en;
    logic timed_ok;
    logic wr_switch;
    logic wr_enable;
    logic [1:0] sel_nxt;
    logic target_ready;
    logic active_lvl;
    logic target_lvl;
    logic en_write_bad;
    logic switch_go;

    // Pins from other clocks pass two flops before any use
    sync2 #(.W(5)) pin_sync (
        .clk(clk),
        .rst(rst),
        .d({fast_osc_clk, slow_osc_clk, ext_input_clk, fast_osc_ready, ext_input_ready}),
        .q(pins_s)
    );

    // Forced fast oscillator during programming; software value kept aside
    assign fast_en_eff = fast_en_r | inapp_program_enable;
    assign ext_en = (ext_field_r == `CS_EXT_ON);
    assign fast_st = inapp_program_enable | (fast_en_eff & pins_s[1]);
    assign ext_st = ext_en & pins_s[0];
    assign fast_osc_on = fast_en_eff;
    assign ext_input_on = ext_en;
    assign shared_io_gpio = ~ext_en;
    assign active_src = active_r;

    // Timed access: key1 then key2 opens a short window for one write
    assign timed_ok = (timed_open_r != 3'h0);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timed_armed_r <= 1'b0;
            timed_open_r <= 3'h0;
        end else begin
            timed_armed_r <= wr && addr == `CS_ADDR_TIMED && wdata == `CS_TIMED_KEY1;
            if (wr && addr == `CS_ADDR_TIMED && wdata == `CS_TIMED_KEY2 && timed_armed_r) begin
                timed_open_r <= `CS_TIMED_OPEN_CYC;
            end else if (wr_switch || wr_enable) begin
                timed_open_r <= 3'h0;
            end else if (timed_ok) begin
                timed_open_r <= timed_open_r - 3'h1;
            end
        end
    end

    assign wr_switch = wr && addr == `CS_ADDR_SWITCH && timed_ok;
    assign wr_enable = wr && addr == `CS_ADDR_ENABLE && timed_ok;
    assign sel_nxt = wr_switch ? wdata[`CS_SEL_HI:`CS_SEL_LO] : sel_r;

    // Is a source enabled and stable
    function automatic logic src_ready(input logic [1:0] s, input logic f, input logic e);
        case (s)
            SRC_FAST: src_ready = f;
            SRC_EXT: src_ready = e;
            SRC_SLOW: src_ready = 1'b1;
            default: src_ready = 1'b0;
        endcase
    endfunction

    assign target_ready = src_ready(sel_r, fast_st, ext_st);

    // Enable write that would stop the running source is dropped whole
    always_comb begin
        case (active_r)
            // Programming mode does not lift this: the saved enable returns after it
            SRC_FAST: en_write_bad = ~wdata[`CS_BIT_FAST_EN];
            SRC_EXT: en_write_bad = wdata[`CS_EXT_HI:`CS_EXT_LO] != `CS_EXT_ON;
            default: en_write_bad = 1'b0;
        endcase
    end

    // Select field takes every unlocked write at once
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sel_r <= SRC_FAST;
        end else begin
            sel_r <= sel_nxt;
        end
    end

    // Enable register fields
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_field_r <= 2'h0;
            fast_en_r <= 1'b1;
        end else if (wr_enable && !en_write_bad) begin
            ext_field_r <= wdata[`CS_EXT_HI:`CS_EXT_LO];
            fast_en_r <= wdata[`CS_BIT_FAST_EN];
        end
    end

    // Glitch-free change: both old and new levels must be low
    always_comb begin
        case (active_r)
            SRC_FAST: active_lvl = pins_s[4];
            SRC_SLOW: active_lvl = pins_s[3];
            default: active_lvl = pins_s[2];
        endcase
        case (sel_r)
            SRC_FAST: target_lvl = pins_s[4];
            SRC_SLOW: target_lvl = pins_s[3];
            default: target_lvl = pins_s[2];
        endcase
    end

    // Background switch, held off while a switch or enable write lands, so a new select or
    // enable is never judged against a source that moves in the same cycle
    assign switch_go = sel_r != active_r && target_ready && !active_lvl && !target_lvl
        && !wr_switch && !wr_enable;

    // Move the running source to the target once it is ready
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            active_r <= SRC_FAST;
        end else if (switch_go) begin
            active_r <= clk_src_t'(sel_r);
        end
    end

    // Fault: set on a request to a source not ready, cleared on completion or on a ready select of the running source
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fault_r <= 1'b0;
        end else if (wr_switch && !src_ready(sel_nxt, fast_st, ext_st)) begin
            fault_r <= 1'b1;
        end else if (wr_switch && sel_nxt == active_r) begin
            fault_r <= 1'b0;
        end else if (switch_go) begin
            fault_r <= 1'b0;
        end
    end

    // Divider setting, free to change while running
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_r <= `CS_DIV_RESET;
        end else if (wr && addr == `CS_ADDR_DIV) begin
            div_r <= wdata;
        end
    end

    // Oscillator clock level of the running source
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            osc_lvl_r <= 1'b0;
            osc_prev_r <= 1'b0;
        end else begin
            osc_lvl_r <= active_lvl;
            osc_prev_r <= osc_lvl_r;
        end
    end

    sys_clk_divider divider (
        .clk(clk),
        .rst(rst),
        .osc_lvl(osc_lvl_r),
        .osc_rise(osc_lvl_r & ~osc_prev_r),
        .osc_fall(~osc_lvl_r & osc_prev_r),
        .div(div_r),
        .sys_clk(sys_clk)
    );

    // Read data one cycle after the strobe; reserved and select read zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (rd) begin
            case (addr)
                `CS_ADDR_SWITCH: rdata <= {2'h0, fast_st, 1'b0, ext_st, 3'h0};
                `CS_ADDR_ENABLE: rdata <= {ext_field_r, fast_en_eff, 4'h0, fault_r};
                `CS_ADDR_DIV: rdata <= div_r;
                default: rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    // Checks
    ext_pin_a: assert property (@(posedge clk) disable iff (rst)
        ext_input_on == (ext_field_r == 2'h3) && shared_io_gpio == !ext_input_on)
        else $error("external input enable does not follow its field");
    iap_force_a: assert property (@(posedge clk) disable iff (rst)
        inapp_program_enable |-> fast_osc_on && fast_st)
        else $error("programming did not force the fast oscillator");
    locked_write_a: assert property (@(posedge clk) disable iff (rst)
        (wr && addr == 8'h96 && timed_open_r == 3'h0) |=> $stable(sel_r))
        else $error("select changed without unlock");
    fault_set_a: assert property (@(posedge clk) disable iff (rst)
        (wr_switch && !src_ready(sel_nxt, fast_st, ext_st)) |=> fault_r && active_r == $past(active_r))
        else $error("fault not set on bad switch");
    disable_drop_a: assert property (@(posedge clk) disable iff (rst)
        (wr_enable && active_r == SRC_FAST && !wdata[5] && !inapp_program_enable) |=> fast_en_r)
        else $error("running fast oscillator was disabled");
    switch_clean_a: assert property (@(posedge clk) disable iff (rst)
        $changed(active_r) |-> !$past(active_lvl) && !$past(target_lvl) && $past(target_ready))
        else $error("source changed without ready target");
    fault_clear_a: assert property (@(posedge clk) disable iff (rst)
        ($changed(active_r) && !$past(wr_switch)) |-> !fault_r)
        else $error("fault left set after switch");
    read_div_a: assert property (@(posedge clk) disable iff (rst)
        (rd && addr == 8'h95) |=> rdata == $past(div_r))
        else $error("divider read back wrong");
    status_gate_a: assert property (@(posedge clk) disable iff (rst)
        (rd && addr == 8'h96 && !ext_en) |=> !rdata[3] && rdata[2:1] == 2'h0)
        else $error("status or select read back wrong");

    // Register access checks
    enable_lock_a: assert property (@(posedge clk) disable iff (rst)
        (wr && addr == 8'h97 && !timed_ok) |=> $stable(ext_field_r) && $stable(fast_en_r))
        else $error("enable changed without unlock");
    window_use_a: assert property (@(posedge clk) disable iff (rst)
        (wr_switch || wr_enable) |=> !timed_ok)
        else $error("unlock window left open after a guarded write");
    reserved_read_a: assert property (@(posedge clk) disable iff (rst)
        (rd && addr == 8'h97) |=> rdata[4:1] == 4'h0)
        else $error("reserved enable bits read nonzero");
    status_fast_a: assert property (@(posedge clk) disable iff (rst)
        (rd && addr == 8'h96 && !fast_osc_on) |=> !rdata[5])
        else $error("fast status set while oscillator off");
    div_write_a: assert property (@(posedge clk) disable iff (rst)
        (wr && addr == 8'h95) |=> div_r == $past(wdata))
        else $error("divider write not taken");

    // Source switching and divider checks
    sel_hold_a: assert property (@(posedge clk) disable iff (rst)
        (sel_r != active_r && !target_ready) |=> $stable(active_r))
        else $error("source moved to a target that is not ready");
    ext_drop_a: assert property (@(posedge clk) disable iff (rst)
        (wr_enable && active_r == SRC_EXT && wdata[7:6] != 2'h3) |=> ext_input_on)
        else $error("running external input was disabled");
    fault_ok_a: assert property (@(posedge clk) disable iff (rst)
        (wr_switch && sel_nxt == active_r && src_ready(sel_nxt, fast_st, ext_st)) |=> !fault_r)
        else $error("fault left set after select of running source");
    div_pass_a: assert property (@(posedge clk) disable iff (rst)
        (div_r == 8'h00) |=> sys_clk == $past(osc_lvl_r))
        else $error("undivided clock does not follow oscillator");

    // Main scenarios reached
    sw_ext_c: cover property (@(posedge clk) disable iff (rst) $changed(active_r) && active_r == SRC_EXT);
    sw_slow_c: cover property (@(posedge clk) disable iff (rst) $changed(active_r) && active_r == SRC_SLOW);
    sw_fast_c: cover property (@(posedge clk) disable iff (rst) $changed(active_r) && active_r == SRC_FAST);
    fault_c: cover property (@(posedge clk) disable iff (rst) $rose(fault_r));
endmodule
`default_nettype wire

/* File: verification/system_clock_source_switch_tb_top.sv */
// Self-checking testbench for the clock source switch block
`timescale 1ns/100ps
`default_nettype none
`include "clk_switch_cfg.svh"
module system_clock_source_switch_tb_top;
    import clk_switch_pkg::*;
    logic clk, rst, wr, rd, fast_osc_clk, fast_osc_ready, slow_osc_clk;
    logic ext_input_clk, ext_input_ready, inapp_program_enable;
    logic [7:0] addr, wdata, rdata, v;
    logic fast_osc_on, ext_input_on, shared_io_gpio, sys_clk;
    clk_src_t active_src;
    int error_cnt = 0;
    int compares = 0;
    int cyc = 0;
    int t0, t1;
    logic [31:0] seed = 32'h0e26;

    clk_source_switch dut (
        .clk(clk),
        .rst(rst),
        .addr(addr),
        .wdata(wdata),
        .wr(wr),
        .rd(rd),
        .rdata(rdata),
        .fast_osc_clk(fast_osc_clk),
        .fast_osc_ready(fast_osc_ready),
        .slow_osc_clk(slow_osc_clk),
        .ext_input_clk(ext_input_clk),
        .ext_input_ready(ext_input_ready),
        .inapp_program_enable(inapp_program_enable),
        .fast_osc_on(fast_osc_on),
        .ext_input_on(ext_input_on),
        .shared_io_gpio(shared_io_gpio),
        .active_src(active_src),
        .sys_clk(sys_clk)
    );

    // System clock, 20 ns period
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Oscillator levels with half periods of 2, 3 and 5 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc % 2 == 1) fast_osc_clk <= ~fast_osc_clk;
        if (cyc % 3 == 2) ext_input_clk <= ~ext_input_clk;
        if (cyc % 5 == 4) slow_osc_clk <= ~slow_osc_clk;
    end

    // Repeatable xorshift source
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Expected read-back of the switch and enable registers
    function automatic logic [7:0] sw_val(input logic fs, input logic es);
        return {2'h0, fs, 1'h0, es, 3'h0};
    endfunction
    function automatic logic [7:0] en_val(input logic [1:0] e, input logic fe, input logic f);
        return {e, fe, 4'h0, f};
    endfunction

    task automatic test_done();
        if (error_cnt == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED time=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Bus cycles: strobe stays up until idle or the next cycle replaces it
    task automatic bw(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        rd <= 1'b0;
        wr <= 1'b1;
    endtask
    task automatic idle();
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
    endtask
    // Unlock sequence followed at once by the guarded write
    task automatic pw(input logic [7:0] a, input logic [7:0] d);
        bw(`CS_ADDR_TIMED, `CS_TIMED_KEY1);
        bw(`CS_ADDR_TIMED, `CS_TIMED_KEY2);
        bw(a, d);
        idle();
    endtask
    // Read data are looked at in the one cycle after the strobe
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        wr <= 1'b0;
        rd <= 1'b1;
        idle();
        chk(rdata, exp);
    endtask
    // Read a register until bit b reads one; running out counts a mismatch
    task automatic poll(input logic [7:0] a, input int b);
        for (int i = 0; i < 50; i++) begin
            @(posedge clk);
            addr <= a;
            wr <= 1'b0;
            rd <= 1'b1;
            idle();
            if (rdata[b] === 1'b1) return;
        end
        error_cnt++;
        test_done();
    endtask

    // Bounded waits; running out counts a mismatch and ends the run
    task automatic wait_src(input clk_src_t s);
        for (int i = 0; i < 300; i++) begin
            if (active_src === s) return;
            @(posedge clk);
            #1;
        end
        error_cnt++;
        test_done();
    endtask
    task automatic wait_chg(output int t);
        logic p;
        p = sys_clk;
        t = 0;
        for (int i = 0; i < 6000; i++) begin
            @(posedge clk);
            #1;
            if (sys_clk !== p) begin
                t = cyc;
                return;
            end
        end
        error_cnt++;
        test_done();
    endtask

    // Main sequence
    initial begin
        rst = 1'b1;
        {wr, rd, addr, wdata} = 18'h0;
        {fast_osc_clk, slow_osc_clk, ext_input_clk} = 3'h0;
        fast_osc_ready = 1'b1;
        ext_input_ready = 1'b0;
        inapp_program_enable = 1'b0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        rchk(`CS_ADDR_SWITCH, sw_val(1'b1, 1'b0));
        rchk(`CS_ADDR_ENABLE, en_val(2'h0, 1'b1, 1'b0));
        // Writes without the unlock must leave both registers alone
        for (int i = 0; i < 4; i++) begin
            v = 8'(rnd());
            bw(`CS_ADDR_SWITCH + {7'h0, v[0]}, v);
            idle();
            rchk(`CS_ADDR_ENABLE, en_val(2'h0, 1'b1, 1'b0));
            chk(active_src, SRC_FAST);
        end
        rchk(8'h10, 8'h00);
        // Every external enable code
        for (int k = 0; k < 4; k++) begin
            pw(`CS_ADDR_ENABLE, {k[1:0], 6'h20});
            chk(ext_input_on, k == 3);
            chk(shared_io_gpio, k != 3);
            rchk(`CS_ADDR_ENABLE, en_val(k[1:0], 1'b1, 1'b0));
        end
        rchk(`CS_ADDR_SWITCH, sw_val(1'b1, 1'b0));
        // Target enabled but unstable: stay, flag, then switch when ready
        pw(`CS_ADDR_SWITCH, 8'h02);
        rchk(`CS_ADDR_ENABLE, en_val(2'h3, 1'b1, 1'b1));
        repeat (10) @(posedge clk);
        rchk(`CS_ADDR_ENABLE, en_val(2'h3, 1'b1, 1'b1));
        chk(active_src, SRC_FAST);
        ext_input_ready <= 1'b1;
        wait_src(SRC_EXT);
        rchk(`CS_ADDR_ENABLE, en_val(2'h3, 1'b1, 1'b0));
        rchk(`CS_ADDR_SWITCH, sw_val(1'b1, 1'b1));
        // Turning off the running source is refused whole
        pw(`CS_ADDR_ENABLE, 8'h20);
        rchk(`CS_ADDR_ENABLE, en_val(2'h3, 1'b1, 1'b0));
        chk(ext_input_on, 1'b1);
        pw(`CS_ADDR_SWITCH, 8'h04);
        wait_src(SRC_SLOW);
        pw(`CS_ADDR_ENABLE, 8'h00);
        chk(fast_osc_on, 1'b0);
        repeat (3) @(posedge clk);
        rchk(`CS_ADDR_SWITCH, sw_val(1'b0, 1'b0));
        // Disabled target and reserved code: flag set, clock kept
        pw(`CS_ADDR_SWITCH, 8'h00);
        rchk(`CS_ADDR_ENABLE, en_val(2'h0, 1'b0, 1'b1));
        pw(`CS_ADDR_SWITCH, 8'h06);
        rchk(`CS_ADDR_ENABLE, en_val(2'h0, 1'b0, 1'b1));
        chk(active_src, SRC_SLOW);
        pw(`CS_ADDR_SWITCH, 8'h04);
        rchk(`CS_ADDR_ENABLE, en_val(2'h0, 1'b0, 1'b0));
        // Programming mode forces the fast oscillator, then restores
        inapp_program_enable <= 1'b1;
        repeat (3) @(posedge clk);
        chk(fast_osc_on, 1'b1);
        rchk(`CS_ADDR_ENABLE, en_val(2'h0, 1'b1, 1'b0));
        rchk(`CS_ADDR_SWITCH, sw_val(1'b1, 1'b0));
        inapp_program_enable <= 1'b0;
        repeat (3) @(posedge clk);
        rchk(`CS_ADDR_ENABLE, en_val(2'h0, 1'b0, 1'b0));
        rchk(`CS_ADDR_SWITCH, sw_val(1'b0, 1'b0));
        // Divider on the slow oscillator, period 10 cycles, changed on the fly
        for (int j = 0; j < 4; j++) begin
            v = (j == 0) ? 8'h00 : (j == 1) ? 8'hFF : 8'(rnd() % 8 + 1);
            bw(`CS_ADDR_DIV, v);
            idle();
            rchk(`CS_ADDR_DIV, v);
            wait_chg(t0);
            wait_chg(t0);
            wait_chg(t1);
            chk(16'(t1 - t0), 16'((v == 0) ? 5 : v * 10));
        end
        // Proper order: enable the target, poll its status, select, then wait for the switch
        fast_osc_ready <= 1'b0;
        pw(`CS_ADDR_ENABLE, 8'h20);
        rchk(`CS_ADDR_SWITCH, sw_val(1'b0, 1'b0));
        fast_osc_ready <= 1'b1;
        poll(`CS_ADDR_SWITCH, 5);
        pw(`CS_ADDR_SWITCH, 8'h00);
        rchk(`CS_ADDR_ENABLE, en_val(2'h0, 1'b1, 1'b0));
        wait_src(SRC_FAST);
        rchk(`CS_ADDR_SWITCH, sw_val(1'b1, 1'b0));
        // Turning off the running fast oscillator is refused whole
        pw(`CS_ADDR_ENABLE, 8'h00);
        rchk(`CS_ADDR_ENABLE, en_val(2'h0, 1'b1, 1'b0));
        chk(fast_osc_on, 1'b1);
        chk(active_src, SRC_FAST);
        test_done();
    end
endmodule
`default_nettype wire
